// File: homing_pkg.sv
/*
  homing_pkg: constants and types for the homing sequencer.
  assumes: one 50 MHz clock, synchronous active-high reset.
*/
package homing_pkg;

  localparam logic [7:0]  MODE_HOMING    = 8'h06;
  localparam int          CTRL_START_BIT = 4;
  localparam int          STAT_B10       = 10;
  localparam int          STAT_B12       = 12;
  localparam int          STAT_B13       = 13;
  localparam logic [15:0] STAT_RESET     = 16'h0400;
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          MS_NS          = 1_000_000;
  localparam int          CLK_NS         = 1_000_000_000 / CLK_HZ;
  localparam int          CYC_PER_MS     = MS_NS / CLK_NS;
  localparam logic [15:0] CYC_PER_MS_W   = 16'(CYC_PER_MS);
  localparam logic signed [7:0] METH_CUR_POS = 8'sd35;

  typedef enum logic [1:0] {
    DIR_NEG,
    DIR_POS,
    DIR_NONE
  } dir_e;

  typedef enum logic [1:0] {
    REF_LIMIT,
    REF_HOME,
    REF_INDEX,
    REF_HERE
  } ref_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_BLOCK,
    ST_ZERO,
    ST_DONE,
    ST_ERROR
  } state_e;

endpackage

// File: homing_sequencer.sv
/*
  homing_sequencer: homing mode state machine of a motor drive.
  assumes: switch, index and standstill pins are asynchronous and are
  synchronised here; current, speeds and settings are on i_clk.
*/
`timescale 1ns/1ns
module homing_sequencer
  import homing_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  input  wire logic [7:0]          i_operating_mode_select,
  input  wire logic [15:0]         i_control_word,
  input  wire logic signed [7:0]   i_method,
  input  wire logic signed [31:0]  i_home_offset,
  input  wire logic [31:0]         i_switch_speed,
  input  wire logic [31:0]         i_zero_speed,
  input  wire logic [31:0]         i_homing_accel,
  input  wire logic [15:0]         i_block_current_min,
  input  wire logic [15:0]         i_block_period_ms,
  input  wire logic [15:0]         i_motor_current,
  input  wire logic                i_closed_loop,
  input  wire logic                i_op_enabled,
  input  wire logic                i_home_switch,
  input  wire logic                i_limit_neg,
  input  wire logic                i_limit_pos,
  input  wire logic                i_index_pulse,
  input  wire logic                i_standstill,
  output logic [15:0]              o_status_word,
  output logic signed [31:0]       o_speed_cmd,
  output logic [31:0]              o_accel_cmd,
  output logic                     o_load_position,
  output logic signed [31:0]       o_position_value
);
  import homing_pkg::*;

  typedef struct packed {
    logic [1:0]         home_s;
    logic [1:0]         lneg_s;
    logic [1:0]         lpos_s;
    logic [1:0]         idx_s;
    logic [1:0]         still_s;
    logic               home_d1;
    logic               idx_d1;
    logic               start_d1;
    state_e             st;
    dir_e               dir;
    ref_e               refk;
    logic               use_idx;
    logic               block;
    logic               edge_rise;
    logic               homed;
    logic               err;
    logic [15:0]        ms_cnt;
    logic [15:0]        blk_ms;
    logic [15:0]        status;
    logic signed [31:0] speed;
    logic [31:0]        accel;
    logic               load;
    logic signed [31:0] pos;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ---------------------------------------------------------------
  // method decode
  // ---------------------------------------------------------------
  function automatic logic [6:0] decode(input logic signed [7:0] m);
    // returns {valid, block, use_idx, dir[1:0], ref[1:0]}
    logic signed [7:0] a;
    logic signed [7:0] b;
    logic              neg;
    logic              idx;
    logic              ok;
    neg = (m < 0);
    a   = neg ? -m : m;
    idx = (a <= 8'sd14) || (a == 8'sd33) || (a == 8'sd34);
    b   = (a >= 8'sd17 && a <= 8'sd30) ? a - 8'sd16 : a;
    ok  = (a >= 8'sd1 && a <= 8'sd14) || (a >= 8'sd17 && a <= 8'sd30) ||
          (!neg && a >= 8'sd33 && a <= 8'sd35);
    // only -1,-2,-7..-14 and the offset-by-16 set
    if (neg && ((b >= 8'sd3 && b <= 8'sd6) || a > 8'sd30))
      ok = 1'b0;
    decode = 7'h00;
    if (a == METH_CUR_POS)
      decode = {ok, 1'b0, 1'b0, DIR_NONE, REF_HERE};
    else if (a == 8'sd33 || a == 8'sd34)
      decode = {ok, 1'b0, 1'b1, (a == 8'sd33) ? DIR_NEG : DIR_POS, REF_INDEX};
    else if (b <= 8'sd2)
      decode = {ok, neg, idx, (b == 8'sd1) ? DIR_NEG : DIR_POS, REF_LIMIT};
    else if (b <= 8'sd6)
      decode = {ok, 1'b0, idx, b[0] ? DIR_NEG : DIR_POS, REF_HOME};
    else
      decode = {ok, neg, idx, (b <= 8'sd10) ? DIR_POS : DIR_NEG, REF_HOME};
  endfunction

  logic [6:0] dec;
  logic       active;
  logic       start_req;
  logic       hit_limit;
  logic       blocked;

  always_comb begin
    s_d       = s_q;
    dec       = decode(i_method);
    // mode 6 makes homing the active mode
    active    = (i_operating_mode_select == MODE_HOMING);
    start_req = active && i_control_word[CTRL_START_BIT];
    hit_limit = (s_q.dir == DIR_NEG) ? s_q.lneg_s[1] : s_q.lpos_s[1];
    // current above threshold marks the block
    blocked   = (i_motor_current > i_block_current_min);

    s_d.home_s   = {s_q.home_s[0], i_home_switch};
    s_d.lneg_s   = {s_q.lneg_s[0], i_limit_neg};
    s_d.lpos_s   = {s_q.lpos_s[0], i_limit_pos};
    s_d.idx_s    = {s_q.idx_s[0], i_index_pulse};
    s_d.still_s  = {s_q.still_s[0], i_standstill};
    s_d.home_d1  = s_q.home_s[1];
    s_d.idx_d1   = s_q.idx_s[1];
    s_d.start_d1 = start_req;
    s_d.load     = 1'b0;

    case (s_q.st)
      ST_IDLE, ST_DONE, ST_ERROR: begin
        s_d.speed = '0;
        if (start_req && !s_q.start_d1) begin
          s_d.use_idx = dec[4];
          s_d.block   = dec[5];
          s_d.dir     = dir_e'(dec[3:2]);
          s_d.refk    = ref_e'(dec[1:0]);
          s_d.err     = 1'b0;
          // block homing refused without closed loop
          if (!dec[6] || (dec[5] && !i_closed_loop)) begin
            s_d.err = 1'b1;
            s_d.st  = ST_ERROR;
          end else if (ref_e'(dec[1:0]) == REF_HERE) begin
            s_d.load = 1'b1;
            s_d.pos  = i_home_offset;
            s_d.st   = ST_DONE;
          end else if (!i_op_enabled) begin
            s_d.err = 1'b1;
            s_d.st  = ST_ERROR;
          end else begin
            s_d.edge_rise = !s_q.home_s[1];
            s_d.st = (ref_e'(dec[1:0]) == REF_INDEX) ? ST_ZERO : ST_SEARCH;
          end
        end
      end
      ST_SEARCH: begin
        s_d.speed = (s_q.dir == DIR_NEG) ? -$signed(i_switch_speed) : $signed(i_switch_speed);
        // on block methods the block replaces the limit switch
        if (s_q.refk == REF_LIMIT && s_q.block && blocked) begin
          s_d.ms_cnt = '0;
          s_d.blk_ms = '0;
          s_d.st     = ST_BLOCK;
        end else if (s_q.refk == REF_LIMIT && !s_q.block && hit_limit) begin
          s_d.st = s_q.use_idx ? ST_ZERO : ST_DONE;
        end else if (s_q.refk == REF_HOME && s_q.home_s[1] != s_q.home_d1) begin
          s_d.st = s_q.use_idx ? ST_ZERO : ST_DONE;
        end else if (s_q.refk == REF_HOME && (s_q.block ? blocked : hit_limit)) begin
          // reverse at the observed limit, or at the block
          s_d.dir = (s_q.dir == DIR_NEG) ? DIR_POS : DIR_NEG;
        end
        if (s_d.st == ST_DONE) begin
          s_d.load = 1'b1;
          s_d.pos  = i_home_offset;
        end
      end
      ST_BLOCK: begin
        // keep pushing for the configured period
        s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
        if (s_q.ms_cnt == CYC_PER_MS_W - 16'h0001) begin
          s_d.ms_cnt = '0;
          s_d.blk_ms = s_q.blk_ms + 16'h0001;
        end
        if (s_q.blk_ms >= i_block_period_ms) begin
          s_d.dir = (s_q.dir == DIR_NEG) ? DIR_POS : DIR_NEG;
          s_d.st  = s_q.use_idx ? ST_ZERO : ST_DONE;
          if (!s_q.use_idx) begin
            s_d.load = 1'b1;
            s_d.pos  = i_home_offset;
          end
        end
      end
      ST_ZERO: begin
        s_d.speed = (s_q.dir == DIR_NEG) ? -$signed(i_zero_speed) : $signed(i_zero_speed);
        // index pulse taken only on its rising edge
        if (s_q.idx_s[1] && !s_q.idx_d1) begin
          s_d.load = 1'b1;
          s_d.pos  = i_home_offset;
          s_d.st   = ST_DONE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // clearing bit 4 aborts a running search
    if (!start_req && (s_q.st == ST_SEARCH || s_q.st == ST_BLOCK || s_q.st == ST_ZERO)) begin
      s_d.st    = ST_IDLE;
      s_d.speed = '0;
      // an abort in the cycle of the reference event must not load
      s_d.load  = 1'b0;
      s_d.pos   = s_q.pos;
    end
    if (!active)
      s_d.speed = '0;

    // homed after first completed run; cleared by runs and errors
    if (s_d.st == ST_DONE)
      s_d.homed = 1'b1;
    else if (s_d.st != ST_IDLE)
      s_d.homed = 1'b0;
    // homing acceleration for start and braking
    s_d.accel = i_homing_accel;

    // status encoding; error reports standstill on bit 10
    s_d.status = '0;
    s_d.status[STAT_B13] = (s_d.st == ST_ERROR);
    s_d.status[STAT_B12] = s_d.homed && s_d.st != ST_ERROR;
    case (s_d.st)
      ST_ERROR: s_d.status[STAT_B10] = s_q.still_s[1];
      ST_IDLE:  s_d.status[STAT_B10] = 1'b1;
      ST_DONE:  s_d.status[STAT_B10] = start_req;
      default:  s_d.status[STAT_B10] = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q        <= '0;
      s_q.st     <= ST_IDLE;
      s_q.dir    <= DIR_NONE;
      s_q.refk   <= REF_HERE;
      s_q.status <= STAT_RESET;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_status_word    = s_q.status;
  assign o_speed_cmd      = s_q.speed;
  assign o_accel_cmd      = s_q.accel;
  // offset held as the reference position
  assign o_load_position  = s_q.load;
  assign o_position_value = s_q.pos;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_error_bits: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_ERROR |-> o_status_word[13] && !o_status_word[12])
    else $error("error state without bit 13 set");
  a_running_bits: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_SEARCH |-> o_status_word[13:12] == 2'b00 && !o_status_word[10])
    else $error("running state status wrong");
  a_done_homed: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_DONE |-> o_status_word[12])
    else $error("done without homed bit");
  a_run_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_ZERO |-> !o_status_word[12])
    else $error("homed bit during run");
  a_load_offset: assert property (@(posedge i_clk) disable iff (i_rst)
    o_load_position |-> s_q.st == ST_DONE)
    else $error("position load outside completion");
  a_abort_stop: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce)
    s_q.st == ST_ZERO && !start_req |=> s_q.st == ST_IDLE)
    else $error("abort not taken");
  a_idle_still: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_IDLE |-> o_speed_cmd == 0)
    else $error("speed while idle");
  a_block_loop: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.st == ST_BLOCK |-> $past(s_q.st) inside {ST_SEARCH, ST_BLOCK})
    else $error("block phase entered wrongly");
endmodule

// File: axis_plant.sv
/* axis_plant: axis with home switch, limits and index for the bench.
   assumes: the speed sign moves the axis one step per clock. */
`timescale 1ns/1ns
module axis_plant (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic signed [31:0] i_speed,
  output logic                    o_home,
  output logic                    o_lim_neg,
  output logic                    o_lim_pos,
  output logic                    o_index,
  output logic                    o_still
);
  int pos_q;
  // mechanical block at +-48 stops travel
  always_ff @(posedge i_clk) begin
    if (i_rst) pos_q <= 10;
    else if (i_speed > 0 && pos_q < 48) pos_q <= pos_q + 1;
    else if (i_speed < 0 && pos_q > -48) pos_q <= pos_q - 1;
  end
  assign o_lim_neg = (pos_q <= -40);
  assign o_lim_pos = (pos_q >= 40);
  assign o_home    = (pos_q >= 0);
  assign o_index   = (pos_q % 16 == 0) && (i_speed != 0);
  assign o_still   = (i_speed == 0);
endmodule

// File: tb_homing_sequencer.sv
/* tb_homing_sequencer: self-checking bench of the homing sequencer.
   assumes: axis_plant stands for the axis and its switches. */
`timescale 1ns/1ns
module tb_homing_sequencer;
  import homing_pkg::*;
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_closed_loop = 0, i_op_enabled = 0;
  logic [7:0] i_operating_mode_select = MODE_HOMING;
  logic [15:0] i_control_word = 16'h0000, i_motor_current = 16'h0000;
  logic signed [7:0] i_method = 8'sd35;
  logic signed [31:0] i_home_offset = 32'sh7b;
  logic [31:0] i_switch_speed = 32'h20, i_homing_accel = 32'h100;
  logic [15:0] o_status_word;
  logic signed [31:0] o_speed_cmd, o_position_value;
  logic [31:0] o_accel_cmd;
  logic o_load_position, home, lneg, lpos, idx, still;
  int error_cnt = 0, comparisons = 0;
  always #10 i_clk = ~i_clk;
  homing_sequencer homing_sequencer_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_operating_mode_select(i_operating_mode_select),
    .i_control_word(i_control_word), .i_method(i_method),
    .i_home_offset(i_home_offset), .i_switch_speed(i_switch_speed),
    .i_zero_speed(32'h8), .i_homing_accel(i_homing_accel),
    .i_block_current_min(16'h100), .i_block_period_ms(16'h1),
    .i_motor_current(i_motor_current), .i_closed_loop(i_closed_loop),
    .i_op_enabled(i_op_enabled), .i_home_switch(home), .i_limit_neg(lneg),
    .i_limit_pos(lpos), .i_index_pulse(idx), .i_standstill(still),
    .o_status_word(o_status_word), .o_speed_cmd(o_speed_cmd),
    .o_accel_cmd(o_accel_cmd), .o_load_position(o_load_position),
    .o_position_value(o_position_value));
  axis_plant axis_plant_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_speed(o_speed_cmd), .o_home(home),
    .o_lim_neg(lneg), .o_lim_pos(lpos), .o_index(idx), .o_still(still));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [15:0] st(input logic [2:0] b);
    st = 16'h0000;
    {st[STAT_B13], st[STAT_B12], st[STAT_B10]} = b;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic go(input logic signed [7:0] m);
    i_method = m;
    i_control_word[CTRL_START_BIT] = 1'b1;
  endtask
  task automatic stop();
    i_control_word[CTRL_START_BIT] = 1'b0;
    cyc(2);
  endtask
  task automatic wait_st(input string name, input logic [2:0] b, input int n);
    for (int k = 0; k < n && o_status_word !== st(b); k++) cyc(1);
    check(name, o_status_word, st(b));
  endtask
  task automatic wait_load(input int n);
    for (int k = 0; k < n && o_load_position !== 1'b1; k++) cyc(1);
    check("load", o_load_position, 1'b1);
    check("done", o_status_word, st(3'b011));
    check("position", o_position_value, i_home_offset);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_mode();
    check("reset", o_status_word, STAT_RESET);
    i_operating_mode_select = 8'h03;
    go(METH_CUR_POS);
    cyc(4);
    check("other mode", o_status_word, st(3'b001));
    stop();
    i_operating_mode_select = MODE_HOMING;
    // clock enable low: a start request must not be taken
    i_ce = 1'b0;
    go(METH_CUR_POS);
    cyc(3);
    check("frozen", o_status_word, st(3'b001));
    stop();
    i_ce = 1'b1;
    $display("done mode select");
  endtask
  task automatic t_here();
    go(METH_CUR_POS);
    wait_load(4);
    cyc(1);
    check("pulse", o_load_position, 1'b0);
    stop();
    check("homed idle", o_status_word, st(3'b010));
    $display("done present position");
  endtask
  task automatic t_runs();
    logic signed [7:0] m[14] = '{1, 2, 3, 6, 10, 14, 19, 22, 26, 30, 33, 34, 17, 18};
    i_op_enabled = 1'b1;
    foreach (m[k]) begin
      i_homing_accel = 32'(k + 5);
      i_switch_speed = 32'(k + 16);
      go(m[k]);
      cyc(2);
      check("running", o_status_word, st(3'b000));
      check("accel", o_accel_cmd, i_homing_accel);
      if (m[k] inside {17, 18})
        check("speed", o_speed_cmd, m[k] == 17 ? -i_switch_speed : i_switch_speed);
      wait_load(400);
      stop();
    end
    $display("done method runs");
  endtask
  task automatic t_abort();
    go(8'sd17);
    cyc(3);
    i_control_word[CTRL_START_BIT] = 1'b0;
    wait_st("abort", 3'b001, 4);
    cyc(1);
    $display("done abort");
  endtask
  task automatic t_block();
    i_closed_loop = 1'b1;
    go(-8'sd17);
    cyc(4);
    i_motor_current = 16'h200;
    cyc(40000);
    check("holding", o_status_word, st(3'b000));
    wait_load(12000);
    i_motor_current = 16'h0000;
    stop();
    $display("done block");
  endtask
  task automatic t_error();
    logic signed [7:0] m[4] = '{15, -3, -1, 17};
    logic cl[4] = '{1, 1, 0, 1};
    logic oe[4] = '{1, 1, 1, 0};
    foreach (m[k]) begin
      i_closed_loop = cl[k];
      i_op_enabled = oe[k];
      // leave the error state first so that each error is seen anew
      go(METH_CUR_POS);
      wait_load(4);
      stop();
      go(m[k]);
      wait_st("error", 3'b101, 8);
      stop();
    end
    $display("done errors");
  endtask
  initial begin
    #(20 * 80000);
    error_cnt++;
    end_sim();
  end
  initial begin
    cyc(2);
    i_rst = 0;
    cyc(1);
    t_mode();
    t_here();
    t_runs();
    t_abort();
    t_block();
    t_error();
    end_sim();
  end
endmodule
